// file: verilog/lpsci_pkg.sv
// Purpose: shared constants and types for the low-power DRAM command interface
// Assumes: pins are driven by the controller on the same core_clk edges
// Notes: mode register layouts here are a chosen encoding of the listed fields
package lpsci_pkg;
  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  localparam int BANKS = 4; // independent banks
  localparam int BANK_BITS = 2; // bank address width
  localparam int ROW_BITS = 13; // row address width
  localparam int COL_BITS = 9; // column address width
  localparam int DATA_BITS = 16; // data word width
  localparam int BYTE_BITS = 8; // one masked byte lane
  localparam int AUTO_PRECHARGE_ADDR_BIT = 10; // address bit for auto/all precharge
  // ----------------------------------------------------------------------
  // command codes as {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_LOAD = 3'h0; // mode register load
  localparam logic [2:0] CMD_REF = 3'h1; // counter refresh
  localparam logic [2:0] CMD_PRE = 3'h2; // precharge
  localparam logic [2:0] CMD_ACT = 3'h3; // bank activate
  localparam logic [2:0] CMD_WRITE = 3'h4; // write
  localparam logic [2:0] CMD_READ = 3'h5; // read
  localparam logic [2:0] CMD_STOP = 3'h6; // burst stop
  localparam logic [2:0] CMD_NOP = 3'h7; // no operation
  // ----------------------------------------------------------------------
  // mode and extended mode register fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] BA_MODE = 2'h0; // selects standard mode register
  localparam logic [1:0] BA_EXT = 2'h2; // selects extended mode register
  localparam int MR_BL_LSB = 0; // burst length code, 3 bits
  localparam int MR_TYPE_BIT = 3; // 1 = interleaved order
  localparam int MR_CL_LSB = 4; // read latency code, 3 bits
  localparam int EMR_PASR_LSB = 0; // refreshed portion code, 3 bits
  localparam int EMR_SRP_LSB = 3; // self refresh period step, 2 bits
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] CL_2 = 3'h2; // latency two; any other code gives three
  localparam logic [2:0] PASR_HALF = 3'h1; // banks 0 and 1
  localparam logic [2:0] PASR_QUARTER = 3'h2; // bank 0 only
  localparam logic [9:0] LEN_1 = 10'h001;
  localparam logic [9:0] LEN_2 = 10'h002;
  localparam logic [9:0] LEN_4 = 10'h004;
  localparam logic [9:0] LEN_8 = 10'h008;
  localparam logic [9:0] LEN_PAGE = 10'h200; // full page, wraps until stopped
  localparam logic [3:0] BANKS_ALL = 4'hF;
  localparam logic [3:0] BANKS_HALF = 4'h3;
  localparam logic [3:0] BANKS_QUARTER = 4'h1;
  localparam logic [12:0] MODE_RESET = 13'h0030; // burst 1, sequential, latency 3
  localparam logic [12:0] EXT_RESET = 13'h0000; // all banks, shortest period
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20; // core_clk period
  localparam int REFRESH_WINDOW_MS = 64; // refresh window
  localparam int REFRESH_COMMANDS = 8192; // refreshes per window
  localparam int SR_INTERVAL_NS = REFRESH_WINDOW_MS * 1000000 / REFRESH_COMMANDS;
  localparam logic [11:0] SR_BASE_CYC = 12'(SR_INTERVAL_NS / CLK_PERIOD_NS); // rounds down
  // ----------------------------------------------------------------------
  // power state, one-hot
  // ----------------------------------------------------------------------
  localparam int PWR_IDX_DOWN = 1;
  localparam int PWR_IDX_SUSP = 2;
  localparam int PWR_IDX_SELF = 3;
  typedef enum logic [3:0] {
    PWR_RUN = 4'h1,
    PWR_DOWN = 4'h2,
    PWR_SUSP = 4'h4,
    PWR_SELF = 4'h8
  } lpsci_pwr_t;
endpackage : lpsci_pkg

// file: verilog/lpsci_core.sv
// Purpose: device-side command decoder, bank state, burst engine and storage
// Assumes: controller pins change on core_clk and are taken at its rising edge
// Notes: storage keeps only the low row bits, so higher rows alias
//
// Functional notes
// [R1] inputs captured only on rising clock edge
// [R2] clock enable low gates internal clock
// [R3] decoder enabled only while chip select low
// [R4] deselected: ignore commands, bursts keep running
// [R5] ras, cas, we, select form command
// [R6] bank address picks command's bank
// [R7] bank address picks mode or extended register
// [R8] activate takes thirteen bits as row
// [R9] read/write take nine bits as column
// [R10] address bit ten requests precharge after burst
// [R11] precharge with bit ten closes all banks
// [R12] read latency two or three cycles
// [R13] burst length 1, 2, 4, 8, page
// [R14] sequential or interleaved burst order
// [R15] new column accepted every cycle
// [R16] controller refreshes 8192 times per 64 ms
// [R17] four independent banks of sixteen-bit words
// [R18] byte masks gate write and read data
// [R19] self refresh period and portion programmable
// [R20] counter refresh supplies row internally
// [R21] customary command truth table encoding
`timescale 1ns/1ps
module lpsci_core #(
  parameter int ROW_KEEP = 2 // low row bits kept in the storage model
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lpsci_pkg::BANK_BITS-1:0] bank_addr,
  input wire logic [lpsci_pkg::ROW_BITS-1:0] addr,
  // data pins
  input wire logic [lpsci_pkg::DATA_BITS-1:0] dq_in,
  output logic [lpsci_pkg::DATA_BITS-1:0] dq_out,
  output logic [lpsci_pkg::DATA_BITS-1:0] dq_oe,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  // status
  output logic [lpsci_pkg::BANKS-1:0] bank_open,
  output logic [lpsci_pkg::ROW_BITS-1:0] refresh_row,
  output logic [lpsci_pkg::BANKS-1:0] refresh_bank_mask,
  output logic power_down_active,
  output logic suspend_active,
  output logic self_refresh_active
);
  import lpsci_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    lpsci_pwr_t pwr; // power / clock gating state
    logic [BANKS-1:0] row_open; // open flag per bank
    logic [BANKS-1:0][ROW_BITS-1:0] row_addr; // open row per bank
    logic [ROW_BITS-1:0] mode_reg; // standard mode register
    logic [ROW_BITS-1:0] ext_reg; // extended mode register
    logic burst_active; // burst has words left
    logic burst_write; // burst direction
    logic burst_auto_pre; // close bank at burst end
    logic [BANK_BITS-1:0] burst_bank; // burst bank
    logic [COL_BITS-1:0] burst_base; // starting column
    logic [COL_BITS-1:0] burst_idx; // next word index
    logic p0v; // read pipe stage 0
    logic [DATA_BITS-1:0] p0d;
    logic p1v; // read pipe stage 1
    logic [DATA_BITS-1:0] p1d;
    logic [DATA_BITS-1:0] dq_out; // driven read word
    logic [DATA_BITS-1:0] dq_oe; // per-bit drive enable
    logic [ROW_BITS-1:0] ref_row; // internal refresh row counter
    logic [11:0] sr_timer; // self refresh interval counter
    logic [BANKS-1:0] sr_banks; // banks kept in self refresh
  } lpsci_state_t;

  localparam int MEM_AW = BANK_BITS + ROW_KEEP + COL_BITS;

  lpsci_state_t s_reg; // registered state
  lpsci_state_t s_next; // next state
  logic [DATA_BITS-1:0] mem [0:(1<<MEM_AW)-1]; // storage model
  logic [2:0] cmd; // decoded command code
  logic act; // internal clock running this edge
  logic sel; // command decoder enabled
  logic busy; // burst or read data still pending
  logic step_valid; // a column access happens this edge
  logic step_write; // that access is a write
  logic step_last; // that access ends its burst
  logic [BANK_BITS-1:0] step_bank; // bank of the access
  logic [COL_BITS-1:0] step_col; // column of the access
  logic [MEM_AW-1:0] step_index; // storage address of the access

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // burst length in words from the mode register
  function automatic logic [9:0] burst_len(input logic [ROW_BITS-1:0] mr);
    logic [2:0] code;
    code = mr[MR_BL_LSB +: 3];
    unique case (code)
      BL_1: burst_len = LEN_1;
      BL_2: burst_len = LEN_2;
      BL_4: burst_len = LEN_4;
      BL_8: burst_len = LEN_8;
      default: burst_len = LEN_PAGE;
    endcase
  endfunction : burst_len

  // column of word idx within a wrapping burst
  function automatic logic [COL_BITS-1:0] col_of(input logic [COL_BITS-1:0] base,
      input logic [COL_BITS-1:0] idx, input logic [ROW_BITS-1:0] mr);
    logic [COL_BITS-1:0] mask;
    logic [COL_BITS-1:0] low;
    mask = COL_BITS'(burst_len(mr) - LEN_1);
    if (mr[MR_TYPE_BIT] && burst_len(mr) != LEN_PAGE)
      low = base ^ idx; // interleaved
    else
      low = COL_BITS'(base + idx); // sequential
    col_of = (base & ~mask) | (low & mask); // [R14]
  endfunction : col_of

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign cmd = {ras_n, cas_n, we_n}; // [R5] [R21]
  assign act = (s_reg.pwr == PWR_RUN) && cke; // [R2]
  assign sel = act && !cs_n; // [R3]
  assign busy = s_reg.burst_active || s_reg.p0v || s_reg.p1v;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    step_valid = 1'b0;
    step_write = s_reg.burst_write;
    step_last = 1'b0;
    step_bank = s_reg.burst_bank;
    step_col = col_of(s_reg.burst_base, s_reg.burst_idx, s_reg.mode_reg);
    unique case (s_reg.pwr)
      PWR_RUN:
      begin
        if (!cke)
        begin
          // clock gated: choose the low-power state
          if (!cs_n && cmd == CMD_REF)
          begin
            s_next.pwr = PWR_SELF; // [R2]
            s_next.ref_row = ROW_BITS'(s_reg.ref_row + 1'b1); // [R20]
            s_next.sr_timer = 12'(SR_BASE_CYC << s_reg.ext_reg[EMR_SRP_LSB +: 2]); // [R19]
            unique case (s_reg.ext_reg[EMR_PASR_LSB +: 3])
              PASR_HALF: s_next.sr_banks = BANKS_HALF;
              PASR_QUARTER: s_next.sr_banks = BANKS_QUARTER;
              default: s_next.sr_banks = BANKS_ALL;
            endcase
            s_next.dq_oe = '0;
          end
          else if (busy)
            s_next.pwr = PWR_SUSP; // pending data freezes
          else
          begin
            s_next.pwr = PWR_DOWN;
            s_next.dq_oe = '0;
          end
        end
        else
        begin
          // running burst advances whatever chip select shows
          if (s_reg.burst_active)
          begin
            step_valid = 1'b1; // [R4]
            step_last = {1'b0, s_reg.burst_idx} == burst_len(s_reg.mode_reg) - LEN_1
              && burst_len(s_reg.mode_reg) != LEN_PAGE; // [R13]
            s_next.burst_idx = COL_BITS'(s_reg.burst_idx + 1'b1);
            if (step_last)
            begin
              s_next.burst_active = 1'b0;
              if (s_reg.burst_auto_pre)
                s_next.row_open[s_reg.burst_bank] = 1'b0; // [R10]
            end
          end
          if (!cs_n)
          begin
            unique case (cmd)
              CMD_ACT:
              begin
                s_next.row_open[bank_addr] = 1'b1; // [R6]
                s_next.row_addr[bank_addr] = addr; // [R8]
              end
              CMD_READ, CMD_WRITE:
              begin
                // a new column cuts any burst short
                step_valid = 1'b1; // [R15]
                step_write = (cmd == CMD_WRITE);
                step_bank = bank_addr; // [R6]
                step_col = addr[COL_BITS-1:0]; // [R9]
                step_last = burst_len(s_reg.mode_reg) == LEN_1;
                s_next.burst_active = !step_last;
                s_next.burst_idx = COL_BITS'(1);
                s_next.burst_base = addr[COL_BITS-1:0];
                s_next.burst_bank = bank_addr;
                s_next.burst_write = step_write;
                s_next.burst_auto_pre = addr[AUTO_PRECHARGE_ADDR_BIT];
                if (step_last && addr[AUTO_PRECHARGE_ADDR_BIT])
                  s_next.row_open[bank_addr] = 1'b0; // [R10]
              end
              CMD_PRE:
              begin
                if (addr[AUTO_PRECHARGE_ADDR_BIT])
                begin
                  s_next.row_open = '0; // [R11]
                  s_next.burst_active = 1'b0;
                end
                else
                begin
                  s_next.row_open[bank_addr] = 1'b0; // [R11]
                  if (bank_addr == s_reg.burst_bank)
                    s_next.burst_active = 1'b0;
                end
              end
              CMD_REF: s_next.ref_row = ROW_BITS'(s_reg.ref_row + 1'b1); // [R20]
              CMD_LOAD:
              begin
                if (bank_addr == BA_MODE)
                  s_next.mode_reg = addr; // [R7]
                else if (bank_addr == BA_EXT)
                  s_next.ext_reg = addr; // [R7]
              end
              CMD_STOP: s_next.burst_active = 1'b0;
              CMD_NOP:
              begin
              end
            endcase
          end
          // read data pipeline, latency taken from the mode register
          s_next.p0v = step_valid && !step_write;
          s_next.p0d = mem[step_index];
          s_next.p1v = s_reg.p0v;
          s_next.p1d = s_reg.p0d;
          if (s_reg.mode_reg[MR_CL_LSB +: 3] == CL_2)
          begin
            s_next.dq_out = s_reg.p0d; // [R12]
            s_next.dq_oe = s_reg.p0v ? {{BYTE_BITS{!upper_byte_mask}},
              {BYTE_BITS{!lower_byte_mask}}} : '0; // [R18]
          end
          else
          begin
            s_next.dq_out = s_reg.p1d; // [R12]
            s_next.dq_oe = s_reg.p1v ? {{BYTE_BITS{!upper_byte_mask}},
              {BYTE_BITS{!lower_byte_mask}}} : '0; // [R18]
          end
        end
      end
      PWR_DOWN, PWR_SUSP:
      begin
        if (cke)
          s_next.pwr = PWR_RUN; // [R2]
      end
      PWR_SELF:
      begin
        if (cke)
        begin
          s_next.pwr = PWR_RUN;
          s_next.sr_banks = '0;
        end
        else if (s_reg.sr_timer == '0)
        begin
          // internal refresh tick at the programmed period
          s_next.sr_timer = 12'(SR_BASE_CYC << s_reg.ext_reg[EMR_SRP_LSB +: 2]); // [R19]
          s_next.ref_row = ROW_BITS'(s_reg.ref_row + 1'b1); // [R20]
        end
        else
          s_next.sr_timer = 12'(s_reg.sr_timer - 1'b1);
      end
      default: s_next.pwr = PWR_RUN; // illegal code recovers
    endcase
  end

  // storage address: bank, low row bits of that bank's open row, column
  assign step_index = {step_bank, s_reg.row_addr[step_bank][ROW_KEEP-1:0], step_col}; // [R17]

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_reg <= '{pwr: PWR_RUN, mode_reg: MODE_RESET, ext_reg: EXT_RESET, default: '0};
    else
      s_reg <= s_next; // [R1]
  end

  // storage writes with per-byte mask, same edge as the command
  always_ff @(posedge core_clk)
  begin
    if (step_valid && step_write)
    begin
      if (!lower_byte_mask)
        mem[step_index][BYTE_BITS-1:0] <= dq_in[BYTE_BITS-1:0]; // [R18]
      if (!upper_byte_mask)
        mem[step_index][DATA_BITS-1:BYTE_BITS] <= dq_in[DATA_BITS-1:BYTE_BITS]; // [R18]
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign dq_out = s_reg.dq_out;
  assign dq_oe = s_reg.dq_oe;
  assign bank_open = s_reg.row_open;
  assign refresh_row = s_reg.ref_row;
  assign refresh_bank_mask = s_reg.sr_banks;
  assign power_down_active = s_reg.pwr[PWR_IDX_DOWN];
  assign suspend_active = s_reg.pwr[PWR_IDX_SUSP];
  assign self_refresh_active = s_reg.pwr[PWR_IDX_SELF];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence rd_cl2;
    sel && cmd == CMD_READ && s_reg.mode_reg[MR_CL_LSB +: 3] == CL_2;
  endsequence
  sequence rd_cl3;
    sel && cmd == CMD_READ && s_reg.mode_reg[MR_CL_LSB +: 3] != CL_2;
  endsequence
  sequence unmasked_run;
    cke && !lower_byte_mask && !upper_byte_mask;
  endsequence

  a_cs_blocks_cmd: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    act && cs_n && !s_reg.burst_active |=> s_reg.row_open == $past(s_reg.row_open))
    else $error("deselected cycle changed bank state");
  a_burst_keeps_going: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    act && cs_n && s_reg.burst_active && !step_last |=> s_reg.burst_active)
    else $error("burst stopped while deselected");
  a_activate_opens: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    sel && cmd == CMD_ACT |=> s_reg.row_open[$past(bank_addr)]
      && s_reg.row_addr[$past(bank_addr)] == $past(addr))
    else $error("activate did not open row");
  a_read_latency_two: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    rd_cl2 ##1 unmasked_run |=> dq_oe == {DATA_BITS{1'b1}})
    else $error("latency two read not driven");
  a_read_latency_three: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    rd_cl3 ##1 cke ##1 unmasked_run |=> dq_oe == {DATA_BITS{1'b1}})
    else $error("latency three read not driven");
  a_precharge_all: assert property (@(posedge core_clk) disable iff (rst) // [R11]
    sel && cmd == CMD_PRE && addr[AUTO_PRECHARGE_ADDR_BIT] |=> s_reg.row_open == '0)
    else $error("precharge all left a bank open");
  a_precharge_one: assert property (@(posedge core_clk) disable iff (rst) // [R11]
    sel && cmd == CMD_PRE && !addr[AUTO_PRECHARGE_ADDR_BIT]
      |=> !s_reg.row_open[$past(bank_addr)])
    else $error("bank precharge left bank open");
  a_auto_close: assert property (@(posedge core_clk) disable iff (rst) // [R10]
    act && cs_n && s_reg.burst_active && step_last && s_reg.burst_auto_pre
      |=> !s_reg.row_open[$past(s_reg.burst_bank)])
    else $error("auto precharge missed at burst end");
  a_mode_load: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    sel && cmd == CMD_LOAD && bank_addr == BA_MODE
      |=> s_reg.mode_reg == $past(addr) && $stable(s_reg.ext_reg))
    else $error("mode register load wrong");
  a_suspend_freeze: assert property (@(posedge core_clk) disable iff (rst) // [R2]
    s_reg.pwr == PWR_SUSP && !cke |=> $stable(s_reg.burst_idx) && $stable(dq_oe))
    else $error("suspended burst advanced");
  a_refresh_count: assert property (@(posedge core_clk) disable iff (rst) // [R20]
    sel && cmd == CMD_REF |=> s_reg.ref_row == ROW_BITS'($past(s_reg.ref_row) + 1'b1))
    else $error("refresh counter did not advance");
endmodule : lpsci_core

// file: sim/lpsci_host.sv
// Purpose: controller model that drives the command and data pins
// Assumes: pins change just after rising core_clk edges
// Notes: released write data shows the inverse of the last word
`timescale 1ns/1ps
module lpsci_host (
  // clock
  input wire logic core_clk,
  // command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [lpsci_pkg::BANK_BITS-1:0] bank_addr,
  output logic [lpsci_pkg::ROW_BITS-1:0] addr,
  // data pins
  output logic [lpsci_pkg::DATA_BITS-1:0] dq_in,
  output logic lower_byte_mask,
  output logic upper_byte_mask
);
  import lpsci_pkg::*;
  // ---------------------------------------------
  // idle levels at time zero
  // ---------------------------------------------
  initial
  begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
    bank_addr = 2'h0;
    addr = 13'h0000;
    dq_in = 16'h0000;
    lower_byte_mask = 1'b0;
    upper_byte_mask = 1'b0;
  end
  // one command, held until the next call
  task automatic issue(input logic [2:0] code, input logic sel_n, input logic [1:0] ba,
                       input logic [12:0] a);
    @(posedge core_clk);
    cs_n <= sel_n;
    {ras_n, cas_n, we_n} <= code;
    bank_addr <= ba;
    addr <= a;
  endtask : issue
  // no operation
  task automatic nop();
    issue(CMD_NOP, 1'b0, 2'h0, 13'h0000);
  endtask : nop
  // write burst of n words d0, d0+1, ... from column col
  task automatic write_burst(input logic [1:0] ba, input logic [8:0] col,
                             input logic [15:0] d0, input int n);
    issue(CMD_WRITE, 1'b0, ba, {4'h0, col});
    dq_in <= d0;
    for (int i = 1; i < n; i++)
    begin
      nop();
      dq_in <= d0 + 16'(i);
    end
    nop();
    dq_in <= ~(d0 + 16'(n - 1)); // released data
  endtask : write_burst
  // one counter refresh; the run is far shorter than one refresh window
  task automatic refresh();
    issue(CMD_REF, 1'b0, 2'h0, 13'h0000);
  endtask : refresh
endmodule : lpsci_host

// file: sim/lowpower_sdram_command_interface_bench.sv
// Purpose: self-checking bench for the DRAM command interface
// Assumes: design answers as in its hand-over timing
// Notes: words are 16'hC300 plus column
`timescale 1ns/1ps
module lowpower_sdram_command_interface_bench;
  import lpsci_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, lower_byte_mask, upper_byte_mask;
  logic [1:0] bank_addr;
  logic [12:0] addr, refresh_row, r0;
  logic [15:0] dq_in, dq_out, dq_oe;
  logic [3:0] bank_open, refresh_bank_mask;
  logic power_down_active, suspend_active, self_refresh_active;
  int bad_count = 0;
  int checked = 0;
  lpsci_host host_u (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr), .dq_in(dq_in),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask));
  lpsci_core dut_u (.core_clk(core_clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .lower_byte_mask(lower_byte_mask),
    .upper_byte_mask(upper_byte_mask), .bank_open(bank_open), .refresh_row(refresh_row),
    .refresh_bank_mask(refresh_bank_mask), .power_down_active(power_down_active),
    .suspend_active(suspend_active), .self_refresh_active(self_refresh_active));
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : check
  task automatic load(input logic [12:0] mode);
    host_u.issue(CMD_LOAD, 1'b0, BA_MODE, mode);
    host_u.nop();
  endtask : load
  // steps n cycles then samples settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // read burst of four from bank 1, expected order worked out here
  task automatic read_chk(input logic [8:0] col, input int cl, input bit il,
                          input logic [15:0] oe);
    logic [8:0] c;
    host_u.issue(CMD_READ, 1'b0, 2'h1, {4'h0, col});
    host_u.nop();
    step(cl - 1);
    for (int i = 0; i < 4; i++)
    begin
      c = il ? (col ^ 9'(i)) : {col[8:2], col[1:0] + 2'(i)};
      check("read oe", dq_oe, oe);
      check("read data", dq_out & oe, (16'hC300 + 16'(c)) & oe);
      step(1);
    end
    check("read end", dq_oe, 16'h0000);
  endtask : read_chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // watchdog
  initial
  begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial
  begin
    step(12);
    rst <= 1'b0;
    step(1);
    check("reset oe", dq_oe, 16'h0000);
    check("reset banks", bank_open, 4'h0);
    $display("test reset done");
    load(13'h0022);
    host_u.issue(CMD_ACT, 1'b0, 2'h1, 13'h1000);
    host_u.nop();
    step(1);
    check("activate", bank_open, 4'h2);
    host_u.write_burst(2'h1, 9'h004, 16'hC304, 4);
    read_chk(9'h004, 2, 1'b0, 16'hFFFF);
    read_chk(9'h005, 2, 1'b0, 16'hFFFF);
    load(13'h002A);
    read_chk(9'h005, 2, 1'b1, 16'hFFFF);
    load(13'h0032);
    read_chk(9'h004, 3, 1'b0, 16'hFFFF);
    host_u.upper_byte_mask <= 1'b1;
    read_chk(9'h004, 3, 1'b0, 16'h00FF);
    host_u.upper_byte_mask <= 1'b0;
    $display("test bursts done");
    host_u.issue(CMD_READ, 1'b1, 2'h1, 13'h0004);
    host_u.nop();
    for (int i = 0; i < 5; i++)
    begin
      step(1);
      check("deselected", dq_oe, 16'h0000);
    end
    load(13'h0022);
    host_u.issue(CMD_READ, 1'b0, 2'h1, 13'h0004);
    host_u.issue(CMD_READ, 1'b0, 2'h1, 13'h0006);
    host_u.nop();
    step(0);
    check("b2b w0", dq_out, 16'hC304);
    step(1);
    check("b2b w1", dq_out, 16'hC306);
    step(1);
    check("b2b w2", dq_out, 16'hC307);
    $display("test back to back done");
    host_u.issue(CMD_ACT, 1'b0, 2'h3, 13'h0000);
    host_u.issue(CMD_PRE, 1'b0, 2'h1, 13'h0000);
    host_u.nop();
    step(1);
    check("single precharge", bank_open, 4'h8);
    host_u.issue(CMD_ACT, 1'b0, 2'h1, 13'h1000);
    host_u.issue(CMD_PRE, 1'b0, 2'h0, 13'h0400);
    host_u.nop();
    step(1);
    check("precharge all", bank_open, 4'h0);
    host_u.issue(CMD_ACT, 1'b0, 2'h2, 13'h0000);
    host_u.issue(CMD_READ, 1'b0, 2'h2, 13'h0404);
    host_u.nop();
    step(10);
    check("auto precharge", bank_open, 4'h0);
    $display("test precharge done");
    r0 = refresh_row;
    host_u.refresh();
    host_u.nop();
    step(2);
    check("refresh row", refresh_row, r0 + 13'h0001);
    host_u.nop();
    host_u.cke <= 1'b0;
    step(2);
    check("power down", power_down_active, 1'b1);
    host_u.nop();
    host_u.cke <= 1'b1;
    step(2);
    check("power up", power_down_active, 1'b0);
    // read pending while clock gated freezes instead of powering down
    host_u.issue(CMD_READ, 1'b0, 2'h0, 13'h0000);
    host_u.nop();
    host_u.cke <= 1'b0;
    step(1);
    check("suspend", suspend_active, 1'b1);
    host_u.nop();
    host_u.cke <= 1'b1;
    step(2);
    check("resume", suspend_active, 1'b0);
    step(8);
    // refresh with clock gated enters self refresh
    host_u.refresh();
    host_u.cke <= 1'b0;
    step(2);
    check("self refresh", self_refresh_active, 1'b1);
    check("sr banks", refresh_bank_mask, BANKS_ALL);
    host_u.nop();
    host_u.cke <= 1'b1;
    step(2);
    check("sr exit", self_refresh_active, 1'b0);
    check("sr banks off", refresh_bank_mask, 4'h0);
    $display("test refresh and power done");
    final_report();
  end
endmodule : lowpower_sdram_command_interface_bench
